// file: common/apsp_pkg.sv
// Package with constants and types for the asynchronous panel strobe port
package apsp_pkg;

  // ===========================================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_PS     = 5000;
  localparam int unsigned RESET_WIDTH_MS    = 1;
  localparam int unsigned RESET_WIDTH_NS    = 15;
  localparam int unsigned RESET_MS_CYCLES   =
    (RESET_WIDTH_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RESET_NS_CYCLES   =
    (RESET_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RESET_CYCLES      =
    (RESET_MS_CYCLES > RESET_NS_CYCLES) ? RESET_MS_CYCLES : RESET_NS_CYCLES;

  // ===========================================================================
  // Widths and reset values
  localparam int unsigned BUS_WIDTH   = 18;
  localparam int unsigned TIME_WIDTH  = 8;
  localparam int unsigned PANEL_COUNT = 3;
  localparam logic [PANEL_COUNT-1:0] SELECT_IDLE = 3'h7;
  localparam logic [1:0]             PANEL_MAX   = 2'h2;
  localparam int unsigned            SYNC_STAGES = 2;

  // ===========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    APSP_IDLE  = 3'b000,
    APSP_SETUP = 3'b001,
    APSP_LOW   = 3'b010,
    APSP_HIGH  = 3'b011,
    APSP_HOLD  = 3'b100
  } apsp_state_type;

endpackage : apsp_pkg

// file: rtl/apsp_reset_pulse.sv
// Panel reset pulse generator driven by a software level
module apsp_reset_pulse
  import apsp_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = RESET_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic request,
  output logic      panel_rst_n
);

  initial begin
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 32'h7FFFFFFF)
      $error("PULSE_CYCLES out of range");
  end

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic        out_reg;
  logic        out_next;

  // ===========================================================================
  // Pulse stays low while requested and at least PULSE_CYCLES
  always_comb begin
    count_next = count_reg;
    out_next   = 1'b1;
    if (request) begin
      count_next = PULSE_CYCLES;
      out_next   = 1'b0;
    end else if (count_reg > 32'h1) begin
      count_next = count_reg - 32'h1;
      out_next   = 1'b0;
    end else begin
      count_next = 32'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 32'h0;
      out_reg   <= 1'b1;
    end else begin
      count_reg <= count_next;
      out_reg   <= out_next;
    end
  end

  assign panel_rst_n = out_reg;

  // ===========================================================================
  // Checks
  reset_min_width_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(out_reg) |-> (count_reg == PULSE_CYCLES) && !out_reg)
    else $error("reset pulse started without full count");

endmodule : apsp_reset_pulse

// file: rtl/apsp_strobe_port.sv
// Strobe sequencer for an 80-series asynchronous panel
// Operation
// - Select and strobes active low, idle high
// - Strobe pulse frames each transfer under select
// - Reads only allowed after a command write
// - Straight data polarity, optional inversion
// - Write low then high minimum widths
// - Read low then high minimum widths
// - Select setup before write strobe falls
// - Select setup before read strobe falls
// - Select held after write strobe rises
// - Select held after read strobe rises
// - Write data setup and hold around rise
// - Read sample after access delay only
// - Panel reset active low, high normally
// - Panel reset low at least 1 ms
// - Panel reset from software level, not sequencer
// - One select per panel, up to three
module apsp_strobe_port
  import apsp_pkg::*;
#(
  parameter int unsigned DW           = BUS_WIDTH,
  parameter int unsigned TW           = TIME_WIDTH,
  parameter int unsigned RESET_PULSE  = RESET_CYCLES
) (
  input  wire logic          REF_CLK,
  input  wire logic          RESETN,
  input  wire logic          REQ_VALID,
  input  wire logic          REQ_READ,
  input  wire logic          REQ_DATA,
  input  wire logic [1:0]    REQ_PANEL,
  input  wire logic [DW-1:0] REQ_WORD,
  output logic               REQ_READY,
  output logic               REQ_REFUSED,
  output logic [DW-1:0]      RD_WORD,
  output logic               RD_VALID,
  input  wire logic          INVERT_DATA,
  input  wire logic [TW-1:0] WRITE_LOW_WIDTH,
  input  wire logic [TW-1:0] WRITE_HIGH_WIDTH,
  input  wire logic [TW-1:0] READ_LOW_WIDTH,
  input  wire logic [TW-1:0] READ_HIGH_WIDTH,
  input  wire logic [TW-1:0] SELECT_SETUP_WRITE,
  input  wire logic [TW-1:0] SELECT_SETUP_READ,
  input  wire logic [TW-1:0] SELECT_HOLD_WRITE,
  input  wire logic [TW-1:0] SELECT_HOLD_READ,
  input  wire logic [TW-1:0] READ_ACCESS_DELAY,
  input  wire logic          PANEL_RESET_REQ,
  output logic [2:0]         PANEL_SELECT_N,
  output logic               CMD_DATA_SELECT,
  output logic               READ_STROBE_N,
  output logic               WRITE_STROBE_N,
  input  wire logic [DW-1:0] PANEL_BUS_WORD_IN,
  output logic [DW-1:0]      PANEL_BUS_WORD_OUT,
  output logic               PANEL_BUS_WORD_OE,
  output logic               PANEL_RESET_N
);

  initial begin
    if (DW < 1 || DW > 24 || TW < 1 || TW > 16)
      $error("apsp_strobe_port width parameter out of range");
  end

  // ===========================================================================
  // Bus input synchroniser
  logic [DW-1:0] bus_meta_reg;
  logic [DW-1:0] bus_sync_reg;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bus_meta_reg <= '0;
      bus_sync_reg <= '0;
    end else begin
      bus_meta_reg <= PANEL_BUS_WORD_IN;
      bus_sync_reg <= bus_meta_reg;
    end
  end

  // ===========================================================================
  // Sequencer state
  apsp_state_type state_reg, state_next;
  logic [TW-1:0]  cnt_reg, cnt_next;
  logic [TW:0]    acc_reg, acc_next;
  logic           read_reg, read_next;
  logic           cmd_seen_reg, cmd_seen_next;
  logic [2:0]     sel_reg, sel_next;
  logic           rs_reg, rs_next;
  logic           rd_reg, rd_next;
  logic           wr_reg, wr_next;
  logic [DW-1:0]  dout_reg, dout_next;
  logic           oe_reg, oe_next;
  logic           ready_reg, ready_next;
  logic           refused_reg, refused_next;
  logic [DW-1:0]  rword_reg, rword_next;
  logic           rvalid_reg, rvalid_next;
  logic           sampled_reg, sampled_next;

  // Each programmed interval counts at least one cycle
  function automatic logic [TW-1:0] at_least_one(input logic [TW-1:0] v);
    at_least_one = (v == '0) ? {{(TW-1){1'b0}}, 1'b1} : v;
  endfunction : at_least_one

  localparam logic [TW-1:0] ONE = {{(TW-1){1'b0}}, 1'b1};

  // Access count also covers the bus synchroniser lag
  localparam logic [TW:0] ACC_ONE = {{TW{1'b0}}, 1'b1};
  localparam logic [TW:0] ACC_LAG = (TW+1)'(SYNC_STAGES);

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    acc_next      = acc_reg;
    read_next     = read_reg;
    cmd_seen_next = cmd_seen_reg;
    sel_next      = sel_reg;
    rs_next       = rs_reg;
    rd_next       = 1'b1;
    wr_next       = 1'b1;
    dout_next     = dout_reg;
    oe_next       = oe_reg;
    ready_next    = 1'b0;
    refused_next  = 1'b0;
    rword_next    = rword_reg;
    rvalid_next   = 1'b0;
    sampled_next  = sampled_reg;
    case (state_reg)
      APSP_IDLE: begin
        sel_next   = SELECT_IDLE;
        oe_next    = 1'b0;
        ready_next = 1'b1;
        if (REQ_VALID && ready_reg) begin
          ready_next = 1'b0;
          if ((REQ_READ && !cmd_seen_reg) || REQ_PANEL > PANEL_MAX) begin
            refused_next = 1'b1;
          end else begin
            // Only the addressed panel is selected
            sel_next = ~(3'h1 << REQ_PANEL);
            rs_next  = REQ_DATA;
            read_next = REQ_READ;
            // Data polarity straight unless inversion asked
            dout_next = INVERT_DATA ? ~REQ_WORD : REQ_WORD;
            oe_next   = !REQ_READ;
            cnt_next  = REQ_READ ? at_least_one(SELECT_SETUP_READ)
                                 : at_least_one(SELECT_SETUP_WRITE);
            if (!REQ_READ && !REQ_DATA)
              cmd_seen_next = 1'b1;
            state_next = APSP_SETUP;
          end
        end
      end
      APSP_SETUP: begin
        if (cnt_reg == ONE) begin
          state_next   = APSP_LOW;
          rd_next      = !read_reg;
          wr_next      = read_reg;
          cnt_next     = read_reg ? at_least_one(READ_LOW_WIDTH)
                                  : at_least_one(WRITE_LOW_WIDTH);
          acc_next     = {1'b0, at_least_one(READ_ACCESS_DELAY)} +
                         ACC_LAG;
          sampled_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - ONE;
        end
      end
      APSP_LOW: begin
        rd_next = !read_reg;
        wr_next = read_reg;
        if (acc_reg != '0)
          acc_next = acc_reg - ACC_ONE;
        if (read_reg && acc_reg == ACC_ONE) begin
          rword_next   = INVERT_DATA ? ~bus_sync_reg : bus_sync_reg;
          sampled_next = 1'b1;
        end
        if (cnt_reg == ONE && (!read_reg || sampled_reg ||
                               acc_reg == ACC_ONE)) begin
          rd_next    = 1'b1;
          wr_next    = 1'b1;
          state_next = APSP_HIGH;
          cnt_next   = read_reg ? at_least_one(SELECT_HOLD_READ)
                                : at_least_one(SELECT_HOLD_WRITE);
          if (read_reg)
            rvalid_next = 1'b1;
        end else if (cnt_reg != ONE) begin
          cnt_next = cnt_reg - ONE;
        end
      end
      APSP_HIGH: begin
        // Select and data stay put through the hold
        if (cnt_reg == ONE) begin
          state_next = APSP_HOLD;
          sel_next   = SELECT_IDLE;
          cnt_next   = read_reg ? at_least_one(READ_HIGH_WIDTH)
                                : at_least_one(WRITE_HIGH_WIDTH);
        end else begin
          cnt_next = cnt_reg - ONE;
        end
      end
      APSP_HOLD: begin
        // Strobe high phase completes the cycle
        if (cnt_reg == ONE) begin
          state_next = APSP_IDLE;
          ready_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - ONE;
        end
      end
      default: begin
        state_next = APSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg    <= APSP_IDLE;
      cnt_reg      <= '0;
      acc_reg      <= '0;
      read_reg     <= 1'b0;
      cmd_seen_reg <= 1'b0;
      sel_reg      <= SELECT_IDLE;
      rs_reg       <= 1'b1;
      rd_reg       <= 1'b1;
      wr_reg       <= 1'b1;
      dout_reg     <= '0;
      oe_reg       <= 1'b0;
      ready_reg    <= 1'b0;
      refused_reg  <= 1'b0;
      rword_reg    <= '0;
      rvalid_reg   <= 1'b0;
      sampled_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      acc_reg      <= acc_next;
      read_reg     <= read_next;
      cmd_seen_reg <= cmd_seen_next;
      sel_reg      <= sel_next;
      rs_reg       <= rs_next;
      rd_reg       <= rd_next;
      wr_reg       <= wr_next;
      dout_reg     <= dout_next;
      oe_reg       <= oe_next;
      ready_reg    <= ready_next;
      refused_reg  <= refused_next;
      rword_reg    <= rword_next;
      rvalid_reg   <= rvalid_next;
      sampled_reg  <= sampled_next;
    end
  end

  // ===========================================================================
  // Panel reset from the software level
  logic prst_n;

  apsp_reset_pulse #(
    .PULSE_CYCLES (RESET_PULSE)
  ) u_reset (
    .clk         (REF_CLK),
    .rst_n       (RESETN),
    .request     (PANEL_RESET_REQ),
    .panel_rst_n (prst_n)
  );

  // ===========================================================================
  // Outputs
  assign REQ_READY          = ready_reg;
  assign REQ_REFUSED        = refused_reg;
  assign RD_WORD            = rword_reg;
  assign RD_VALID           = rvalid_reg;
  assign PANEL_SELECT_N     = sel_reg;
  assign CMD_DATA_SELECT    = rs_reg;
  assign READ_STROBE_N      = rd_reg;
  assign WRITE_STROBE_N     = wr_reg;
  assign PANEL_BUS_WORD_OUT = dout_reg;
  assign PANEL_BUS_WORD_OE  = oe_reg;
  assign PANEL_RESET_N      = prst_n;

  // ===========================================================================
  // Checks
  sequence strobe_low_s;
    !rd_reg || !wr_reg;
  endsequence

  strobe_under_select_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    strobe_low_s |-> (sel_reg != SELECT_IDLE))
    else $error("strobe low without panel select");

  strobes_exclusive_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    !(!rd_reg && !wr_reg))
    else $error("read and write strobes both low");

  one_select_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    $onehot0(~sel_reg))
    else $error("more than one panel selected");

  read_needs_cmd_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    $fell(rd_reg) |-> cmd_seen_reg)
    else $error("read strobe without prior command");

  rs_stable_low_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    strobe_low_s |-> $stable(rs_reg) && state_reg != APSP_IDLE)
    else $error("select line moved during strobe");

  rs_hold_write_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    $rose(wr_reg) |=> $stable(rs_reg) && $stable(dout_reg) && oe_reg)
    else $error("select or data not held after write");

  write_min_low_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    $fell(wr_reg) && WRITE_LOW_WIDTH == 8'h02 |=> !wr_reg)
    else $error("write low phase too short");

  read_sample_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    $rose(rd_reg) |-> sampled_reg || $past(acc_reg) == ACC_ONE)
    else $error("read strobe rose before access delay");

  reset_idle_high_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    !PANEL_RESET_REQ [*2] ##1 (u_reset.count_reg == 32'h0) |-> prst_n)
    else $error("panel reset low in normal operation");

endmodule : apsp_strobe_port

// file: test/apsp_panel_model.sv
// Behavioural smart panel on the far side of the strobe port
module apsp_panel_model
  import apsp_pkg::*;
#(
  parameter int unsigned DLY = 1
) (
  input  wire logic                 clk,
  input  wire logic [2:0]           sel_n,
  input  wire logic                 rs,
  input  wire logic                 rd_n,
  input  wire logic                 wr_n,
  input  wire logic [BUS_WIDTH-1:0] bus,
  output logic      [BUS_WIDTH-1:0] drive,
  output logic      [BUS_WIDTH-1:0] last_word,
  output logic      [2:0]           last_sel,
  output logic                      last_rs,
  output logic      [BUS_WIDTH-1:0] index_reg
);
  // ===========================================================================
  // Latch and reply
  logic        wr_q;
  int unsigned acc;
  initial begin
    drive = 18'h0;
    wr_q = 1'b1;
    acc = 0;
  end
  always @(posedge clk) begin
    wr_q <= wr_n;
    if (wr_n && !wr_q && sel_n != 3'h7) begin
      last_word <= bus;
      last_sel <= sel_n;
      last_rs <= rs;
      if (!rs)
        index_reg <= bus;
    end
    if (!rd_n && sel_n != 3'h7) begin
      acc <= acc + 1;
      if (acc + 1 >= DLY)
        drive <= index_reg ^ 18'h2D2D3;
    end else begin
      acc <= 0;
      drive <= ~drive; // Released bus keeps no stable value
    end
  end
endmodule : apsp_panel_model

// file: test/tb_async_panel_strobe_port.sv
// Self-checking bench for the asynchronous panel strobe port
module tb_async_panel_strobe_port
  import apsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PULSE = 20;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 valid = 1'b0, rd = 1'b0, dsel = 1'b0;
  logic                 inv = 1'b0, prst = 1'b0;
  logic [1:0]           panel = 2'h0;
  logic [BUS_WIDTH-1:0] word = 18'h0, bus_in, rd_word, drv, out, lw, idx;
  logic [7:0]           tim [9];
  logic                 ready, refused, rd_valid, oe, rs, rdn, wrn, prn, lrs;
  logic [2:0]           seln, lsel;
  int                   fails = 0, compares = 0, cyc = 0, wl = 0, rl = 0;

  always #2.5 clk = ~clk;
  assign bus_in = oe ? out : drv;

  apsp_strobe_port #(.RESET_PULSE(PULSE)) u_dut (
    .REF_CLK(clk), .RESETN(rst_n), .REQ_VALID(valid), .REQ_READ(rd),
    .REQ_DATA(dsel), .REQ_PANEL(panel), .REQ_WORD(word),
    .REQ_READY(ready), .REQ_REFUSED(refused), .RD_WORD(rd_word),
    .RD_VALID(rd_valid), .INVERT_DATA(inv), .WRITE_LOW_WIDTH(tim[0]),
    .WRITE_HIGH_WIDTH(tim[1]), .READ_LOW_WIDTH(tim[2]),
    .READ_HIGH_WIDTH(tim[3]), .SELECT_SETUP_WRITE(tim[4]),
    .SELECT_SETUP_READ(tim[5]), .SELECT_HOLD_WRITE(tim[6]),
    .SELECT_HOLD_READ(tim[7]), .READ_ACCESS_DELAY(tim[8]),
    .PANEL_RESET_REQ(prst), .PANEL_SELECT_N(seln), .CMD_DATA_SELECT(rs),
    .READ_STROBE_N(rdn), .WRITE_STROBE_N(wrn),
    .PANEL_BUS_WORD_IN(bus_in), .PANEL_BUS_WORD_OUT(out),
    .PANEL_BUS_WORD_OE(oe), .PANEL_RESET_N(prn));

  apsp_panel_model u_panel (
    .clk(clk), .sel_n(seln), .rs(rs), .rd_n(rdn), .wr_n(wrn), .bus(bus_in),
    .drive(drv), .last_word(lw), .last_sel(lsel), .last_rs(lrs),
    .index_reg(idx));

  // ===========================================================================
  // Checks and expectations
  task automatic end_of_test();
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk_word(input logic [BUS_WIDTH-1:0] g, e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_ctl(input logic [2:0] g, e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_ctl

  function automatic int lo(input logic [7:0] v);
    return (v == 8'h00) ? 1 : int'(v);
  endfunction : lo

  function automatic logic [BUS_WIDTH-1:0] reply(input logic [17:0] i);
    return i ^ 18'h2D2D3;
  endfunction : reply

  // ===========================================================================
  // Wire monitor and timeout
  always @(negedge clk) begin
    cyc++;
    chk_ctl((!wrn || !rdn) && seln === 3'h7, 3'h0);
    chk_ctl($countones(~seln) <= 1, 3'h1);
    if (!wrn) begin
      wl++;
      chk_ctl(oe, 3'h1);
    end else if (wl != 0) begin
      chk_ctl(wl >= lo(tim[0]), 3'h1);
      wl = 0;
    end
    if (!rdn) begin
      rl++;
    end else if (rl != 0) begin
      chk_ctl(rl >= lo(tim[2]), 3'h1);
      rl = 0;
    end
    if (cyc > 30000) begin
      fails++;
      end_of_test();
    end
  end

  // ===========================================================================
  // Requests
  task automatic req(input logic r, d, input logic [1:0] p,
                     input logic [BUS_WIDTH-1:0] w, output logic rf, rv);
    int n;
    n = 0;
    rf = 1'b0;
    rv = 1'b0;
    valid = 1'b1;
    rd = r;
    dsel = d;
    panel = p;
    word = w;
    while (ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (ready !== 1'b1)
      fails++;
    @(negedge clk);
    valid = 1'b0;
    n = 0;
    while ((ready !== 1'b1 || n < 2) && n < 400) begin
      if (refused === 1'b1)
        rf = 1'b1;
      if (rd_valid === 1'b1)
        rv = 1'b1;
      @(negedge clk);
      n++;
    end
    if (n >= 400)
      fails++;
  endtask : req

  task automatic wr(input logic d, input logic [1:0] p,
                    input logic [BUS_WIDTH-1:0] w);
    logic rf, rv;
    req(1'b0, d, p, w, rf, rv);
    chk_ctl(rf, 3'h0);
    chk_word(lw, w ^ {BUS_WIDTH{inv}});
    chk_ctl(lsel, ~(3'h1 << p));
    chk_ctl(lrs, d);
    if (!d)
      chk_word(idx, w ^ {BUS_WIDTH{inv}});
  endtask : wr

  task automatic rdx(input logic [1:0] p, input logic [BUS_WIDTH-1:0] ix);
    logic rf, rv;
    req(1'b1, 1'b1, p, 18'h0, rf, rv);
    chk_ctl({rf, rv}, 3'h1);
    chk_word(rd_word, reply(ix) ^ {BUS_WIDTH{inv}});
  endtask : rdx

  task automatic pulse(input int len);
    int c, m;
    c = 0;
    m = len + PULSE - 1;
    prst = 1'b1;
    for (int i = 0; i < m + 6; i++) begin
      if (i == len)
        prst = 1'b0;
      c += int'(prn === 1'b0);
      @(negedge clk);
    end
    chk_ctl(c >= m && c <= m + 3, 3'h1);
    chk_ctl(prn, 3'h1);
  endtask : pulse

  // ===========================================================================
  // Main sequence
  initial begin
    logic                 rf, rv;
    logic [1:0]           p;
    logic [BUS_WIDTH-1:0] w;
    foreach (tim[i]) tim[i] = 8'h01;
    void'($urandom(32'h0E2282FD));
    repeat (6) @(negedge clk);
    chk_ctl(seln, 3'h7);
    chk_ctl({wrn, rdn, prn}, 3'h7);
    rst_n = 1'b1;
    @(negedge clk);
    req(1'b1, 1'b1, 2'h0, 18'h0, rf, rv);
    chk_ctl(rf, 3'h1);
    wr(1'b1, 2'h2, 18'h3FFFF);
    req(1'b1, 1'b1, 2'h2, 18'h0, rf, rv);
    chk_ctl(rf, 3'h1);
    req(1'b0, 1'b0, 2'h3, 18'h1, rf, rv);
    chk_ctl(rf, 3'h1);
    repeat (40) begin
      foreach (tim[i]) tim[i] = 8'($urandom_range(0, 4));
      tim[8] = 8'($urandom_range(5, 8));
      inv = 1'($urandom_range(0, 1));
      p = 2'($urandom_range(0, 2));
      w = 18'($urandom);
      wr(1'b0, p, w);
      wr(1'b1, p, 18'($urandom));
      rdx(p, w ^ {BUS_WIDTH{inv}});
    end
    pulse(2);
    pulse(PULSE + 10);
    end_of_test();
  end
endmodule : tb_async_panel_strobe_port
